// file: core/fs_pkg.sv
// Purpose: Constants and types shared by the frequency supervisor.
// Assumes: 32-bit AXI4-Lite register access, one 20 MHz clock.
// Notes: Offsets are byte addresses of aligned 32-bit words.
package fs_pkg;

   localparam int FS_ADDR_W = 6;
   typedef logic [FS_ADDR_W-1:0] fs_addr_t;
   typedef logic [8:0] fs_lim_t;

   localparam fs_addr_t FS_OFS_WCTL = 6'h00;
   localparam fs_addr_t FS_OFS_DCTL = 6'h04;
   localparam fs_addr_t FS_OFS_LO0 = 6'h08;
   localparam fs_addr_t FS_OFS_LO1 = 6'h0C;
   localparam fs_addr_t FS_OFS_HI0 = 6'h10;
   localparam fs_addr_t FS_OFS_HI1 = 6'h14;
   localparam fs_addr_t FS_OFS_RST = 6'h18;
   localparam fs_addr_t FS_OFS_STAT = 6'h1C;
   localparam fs_addr_t FS_OFS_MON = 6'h20;

   localparam logic [7:0] FS_CODE_LOCK = 8'h06;
   localparam logic [7:0] FS_CODE_UNLOCK = 8'hF9;
   localparam logic [7:0] FS_CODE_DIS = 8'h00;
   localparam logic [7:0] FS_CODE_EN = 8'hE4;

   localparam logic [7:0] FS_RST_WCTL = 8'h06;
   localparam logic [7:0] FS_RST_DCTL = 8'h00;
   localparam fs_lim_t FS_RST_LIM = 9'h000;
   localparam logic FS_RST_RSTEN = 1'b1;
   localparam logic FS_RST_MON = 1'b1;

   localparam int FS_BIT_ERR = 0;
   localparam int FS_BIT_STOP = 1;

   // Window length in reference periods and the last count of a window.
   localparam int FS_WIN_LEN = 256;
   localparam logic [7:0] FS_WIN_LAST = 8'(FS_WIN_LEN - 1);
   localparam logic [10:0] FS_TCNT_MAX = 11'h7FF;

   localparam logic [1:0] FS_RESP_OKAY = 2'h0;
   localparam logic [1:0] FS_RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      FS_ST_STOP = 3'b001,
      FS_ST_WARM = 3'b010,
      FS_ST_RUN = 3'b100
   } fs_state_e;

endpackage

// file: core/fs_top.sv
// Purpose: Oscillation frequency supervisor with AXI4-Lite registers.
// Assumes: Oscillator inputs are sampled as synchronous levels on clk.
// Notes: The reset request output never resets this block itself.
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps

module fs_top
(
   input wire logic clk,
   input wire logic rst,
   input wire fs_pkg::fs_addr_t s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire fs_pkg::fs_addr_t s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic internal_osc_two,
   input wire logic internal_osc_one,
   input wire logic external_osc,
   input wire logic osc_select_external,
   output logic system_reset_req,
   output logic reset_factor_set
);

   import fs_pkg::*;

   typedef struct packed {
      logic [7:0] wctl;
      logic [7:0] dctl;
      fs_lim_t lo0;
      fs_lim_t lo1;
      fs_lim_t hi0;
      fs_lim_t hi1;
      logic rsten;
      logic mon;
      fs_state_e st;
      logic ref_p;
      logic tgt_p;
      logic [7:0] rcnt;
      logic [10:0] tcnt;
      logic warm;
      logic err;
      logic [1:0] pend;
      logic sysrst;
      logic cause;
      logic aw_have;
      fs_addr_t aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } fs_state_s;

   fs_state_s s_q;
   fs_state_s s_d;

   localparam fs_state_s FS_RESET = '{
      wctl: FS_RST_WCTL,
      dctl: FS_RST_DCTL,
      lo0: FS_RST_LIM,
      lo1: FS_RST_LIM,
      hi0: FS_RST_LIM,
      hi1: FS_RST_LIM,
      rsten: FS_RST_RSTEN,
      mon: FS_RST_MON,
      st: FS_ST_STOP,
      default: '0
   };

   function automatic logic fs_mapped(input fs_addr_t a);
      fs_mapped = (a == FS_OFS_WCTL) || (a == FS_OFS_DCTL) ||
                  (a == FS_OFS_LO0) || (a == FS_OFS_LO1) ||
                  (a == FS_OFS_HI0) || (a == FS_OFS_HI1) ||
                  (a == FS_OFS_RST) || (a == FS_OFS_STAT) ||
                  (a == FS_OFS_MON);
   endfunction

   // Byte-lane merge of a 9-bit field; lane 1 carries bit 8.
   function automatic fs_lim_t fs_merge9(input fs_lim_t old, input logic [31:0] d,
                                         input logic [3:0] b);
      fs_merge9 = {b[1] ? d[8] : old[8], b[0] ? d[7:0] : old[7:0]};
   endfunction

   function automatic logic [31:0] fs_read(input fs_addr_t a, input fs_state_s s);
      fs_read = 32'h0000_0000;
      case (a)
         FS_OFS_WCTL: fs_read[7:0] = s.wctl;
         FS_OFS_DCTL: fs_read[7:0] = s.dctl;
         FS_OFS_LO0: fs_read[8:0] = s.lo0;
         FS_OFS_LO1: fs_read[8:0] = s.lo1;
         FS_OFS_HI0: fs_read[8:0] = s.hi0;
         FS_OFS_HI1: fs_read[8:0] = s.hi1;
         FS_OFS_RST: fs_read[0] = s.rsten;
         FS_OFS_STAT: begin
            fs_read[FS_BIT_STOP] = (s.st == FS_ST_STOP);
            fs_read[FS_BIT_ERR] = s.err;
         end
         FS_OFS_MON: fs_read[0] = s.mon;
         default: fs_read = 32'h0000_0000;
      endcase
   endfunction

   logic ref_rise;
   logic tgt_lvl;
   logic tgt_rise;
   logic tgt_ext;
   logic unlocked;
   logic idle;
   logic do_wr;
   logic win_end;
   logic bad;
   fs_lim_t lo_sel;
   fs_lim_t hi_sel;

   always_comb begin
      s_d = s_q;
      s_d.sysrst = 1'b0;
      s_d.cause = 1'b0;

      // Reference is the second internal oscillator; target is external when mon or the select is set.
      tgt_ext = s_q.mon | osc_select_external;
      tgt_lvl = tgt_ext ? external_osc : internal_osc_one;
      ref_rise = internal_osc_two & ~s_q.ref_p;
      tgt_rise = tgt_lvl & ~s_q.tgt_p;
      s_d.ref_p = internal_osc_two;
      s_d.tgt_p = tgt_lvl;
      lo_sel = tgt_ext ? s_q.lo1 : s_q.lo0;
      hi_sel = tgt_ext ? s_q.hi1 : s_q.hi0;

      unlocked = (s_q.wctl == FS_CODE_UNLOCK);
      idle = (s_q.st == FS_ST_STOP);

      // Write address and data are taken independently, in either order.
      if (s_axi_awvalid && s_q.awready) begin
         s_d.aw_have = 1'b1;
         s_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_q.wready) begin
         s_d.w_have = 1'b1;
         s_d.w_data = s_axi_wdata;
         s_d.w_strb = s_axi_wstrb;
      end

      do_wr = s_q.aw_have && s_q.w_have && !s_q.bvalid;
      if (do_wr) begin
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = fs_mapped(s_q.aw_addr) ? FS_RESP_OKAY : FS_RESP_SLVERR;
         case (s_q.aw_addr)
            FS_OFS_WCTL: begin
               // Any value written with lane 0 enabled, other than the unlock code, relocks.
               if (s_q.w_strb[0]) begin
                  s_d.wctl = (s_q.w_data[7:0] == FS_CODE_UNLOCK) ?
                             FS_CODE_UNLOCK : FS_CODE_LOCK;
               end
            end
            FS_OFS_DCTL: begin
               if (unlocked && s_q.w_strb[0] &&
                   (s_q.w_data[7:0] == FS_CODE_DIS ||
                    s_q.w_data[7:0] == FS_CODE_EN)) begin
                  s_d.dctl = s_q.w_data[7:0];
               end
            end
            FS_OFS_LO0: begin
               if (unlocked && idle) begin
                  s_d.lo0 = fs_merge9(s_q.lo0, s_q.w_data, s_q.w_strb);
               end
            end
            FS_OFS_LO1: begin
               if (unlocked && idle) begin
                  s_d.lo1 = fs_merge9(s_q.lo1, s_q.w_data, s_q.w_strb);
               end
            end
            FS_OFS_HI0: begin
               if (unlocked && idle) begin
                  s_d.hi0 = fs_merge9(s_q.hi0, s_q.w_data, s_q.w_strb);
               end
            end
            FS_OFS_HI1: begin
               if (unlocked && idle) begin
                  s_d.hi1 = fs_merge9(s_q.hi1, s_q.w_data, s_q.w_strb);
               end
            end
            FS_OFS_RST: begin
               if (unlocked && idle && s_q.w_strb[0]) begin
                  s_d.rsten = s_q.w_data[0];
               end
            end
            FS_OFS_MON: begin
               if (unlocked && idle && s_q.w_strb[0]) begin
                  s_d.mon = s_q.w_data[0];
               end
            end
            default: begin
            end
         endcase
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      // Ready drops while a half is held or a response waits, so one write at a time.
      s_d.awready = !s_d.aw_have && !s_d.bvalid;
      s_d.wready = !s_d.w_have && !s_d.bvalid;

      if (s_axi_arvalid && s_q.arready) begin
         s_d.rvalid = 1'b1;
         s_d.rdata = fs_read(s_axi_araddr, s_q);
         s_d.rresp = fs_mapped(s_axi_araddr) ? FS_RESP_OKAY : FS_RESP_SLVERR;
      end else if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      s_d.arready = !s_d.rvalid;

      // Detection window: 256 reference rising edges.
      win_end = ref_rise && (s_q.rcnt == FS_WIN_LAST);
      bad = (s_q.tcnt[10:2] > hi_sel) || (s_q.tcnt[10:2] < lo_sel);
      unique case (s_q.st)
         FS_ST_STOP: begin
            if (s_d.dctl == FS_CODE_EN) begin
               s_d.st = FS_ST_WARM;
               s_d.rcnt = 8'h00;
               s_d.tcnt = 11'h000;
               s_d.warm = 1'b0;
               s_d.pend = 2'b00;
            end
         end
         FS_ST_WARM, FS_ST_RUN: begin
            if (ref_rise) begin
               s_d.rcnt = s_q.rcnt + 8'h01;
            end
            // Saturation keeps a far-too-fast target reading as too fast.
            if (tgt_rise && s_q.tcnt != FS_TCNT_MAX) begin
               s_d.tcnt = s_q.tcnt + 11'h001;
            end
            if (win_end) begin
               s_d.tcnt = 11'h000;
               if (s_q.st == FS_ST_WARM) begin
                  s_d.warm = 1'b1;
                  if (s_q.warm) begin
                     s_d.st = FS_ST_RUN;
                  end
               end else begin
                  s_d.err = bad;
                  s_d.pend = {s_q.pend[0], bad};
                  // Fires at each window end that comes two windows after a failed evaluation.
                  if (s_q.pend[1] && s_q.rsten) begin
                     s_d.sysrst = 1'b1;
                     s_d.cause = 1'b1;
                  end
               end
            end
         end
      endcase
      if (s_d.dctl != FS_CODE_EN) begin
         s_d.st = FS_ST_STOP;
         s_d.err = 1'b0;
         s_d.pend = 2'b00;
         s_d.warm = 1'b0;
      end
   end

   // Only the rst port resets this state; the request output feeds the system.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= FS_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign s_axi_awready = s_q.awready;
   assign s_axi_wready = s_q.wready;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_arready = s_q.arready;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign s_axi_rvalid = s_q.rvalid;
   assign system_reset_req = s_q.sysrst;
   assign reset_factor_set = s_q.cause;

endmodule

// file: verification/fs_asserts.sv
// Purpose: Bus handshake and reset-request checks for fs_top.
// Assumes: One clock domain and an active-high asynchronous reset.
// Notes: Windows last 1024 clocks or more, so requests never come closer than 9 clocks.
`timescale 1ns/1ps
module fs_asserts(
   input wire logic clk,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic system_reset_req,
   input wire logic reset_factor_set
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_cause; system_reset_req |-> reset_factor_set; endproperty
   a_cause: assert property (p_cause) else $error("reset cause missing");
   property p_only; reset_factor_set |-> system_reset_req; endproperty
   a_only: assert property (p_only) else $error("stray reset cause");
   property p_pulse; system_reset_req |=> !system_reset_req [*8]; endproperty
   a_pulse: assert property (p_pulse) else $error("reset request too long");
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read answer dropped");
   property p_awref; s_axi_bvalid |-> !s_axi_awready; endproperty
   a_awref: assert property (p_awref) else $error("address taken during answer");
   property p_arref; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_arref: assert property (p_arref) else $error("read address taken during answer");
   property p_wans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid; endproperty
   a_wans: assert property (p_wans) else $error("write not answered");
   property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rans: assert property (p_rans) else $error("read not answered");
endmodule
bind fs_top fs_asserts i_fs_asserts(.*);

// file: verification/fs_osc_model.sv
// Purpose: Oscillators and oscillator select of the clock generator.
// Assumes: Half periods are given in clocks and are 2 or more.
// Notes: The select falls back to internal after a reset request, as a real reset would.
`timescale 1ns/1ps
module fs_osc_model(
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] ref_half,
   input wire logic [3:0] one_half,
   input wire logic [3:0] ext_half,
   input wire logic sel_req,
   input wire logic system_reset_req,
   output logic internal_osc_two,
   output logic internal_osc_one,
   output logic external_osc,
   output logic osc_select_external
);
   logic [3:0] half [3];
   logic [3:0] cnt_q [3];
   logic [2:0] osc_q;
   logic fell_q;
   assign half = '{ext_half, one_half, ref_half};
   assign {internal_osc_two, internal_osc_one, external_osc} = osc_q;
   assign osc_select_external = sel_req & ~fell_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '{default: 4'h0};
         osc_q <= 3'h0;
         fell_q <= 1'b0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            cnt_q[i] <= (cnt_q[i] >= half[i] - 4'h1) ? 4'h0 : cnt_q[i] + 4'h1;
            if (cnt_q[i] >= half[i] - 4'h1) osc_q[i] <= ~osc_q[i];
         end
         if (system_reset_req) fell_q <= 1'b1;
         else if (!sel_req) fell_q <= 1'b0;
      end
   end
endmodule

// file: verification/fs_tb_top.sv
// Purpose: Self-checking bench for the frequency supervisor.
// Assumes: Reference toggles every 2 clocks, so one window is 1024 clocks.
// Notes: Random data come from a fixed-seed xorshift.
`timescale 1ns/1ps
module fs_tb_top;
   import fs_pkg::*;
   localparam int WIN = 1024;
   logic clk, rst, awvalid, wvalid, bready, arvalid, rready, sel_req;
   logic awready, wready, bvalid, arready, rvalid, sys_rst, cause, osc2, osc1, osce, osel;
   fs_addr_t awaddr, araddr;
   logic [31:0] wdata, rdata, rdv, seed, v;
   logic [3:0] wstrb, ref_h, one_h, ext_h;
   logic [1:0] bresp, rresp, wr_resp, rd_resp;
   int err_count, samples_checked, pulses, causes, cyc, t_last, t_prev, t_first, t0;
   logic [31:0] rst_val [10] = '{32'h6, 0, 0, 0, 0, 0, 1, 2, 1, 0};
   fs_top i_fs_top(.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .internal_osc_two(osc2),
      .internal_osc_one(osc1), .external_osc(osce), .osc_select_external(osel),
      .system_reset_req(sys_rst), .reset_factor_set(cause));
   fs_osc_model i_fs_osc_model(.clk(clk), .rst(rst), .ref_half(ref_h), .one_half(one_h),
      .ext_half(ext_h), .sel_req(sel_req), .system_reset_req(sys_rst),
      .internal_osc_two(osc2), .internal_osc_one(osc1), .external_osc(osce),
      .osc_select_external(osel));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [31:0] stat(logic err, logic run);
      return {30'h0, ~run, err};
   endfunction
   task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic wr(fs_addr_t a, logic [31:0] d);
      logic ta, tw, tb;
      @(posedge clk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
      tb = 1'b0;
      while (!tb) begin
         @(negedge clk);
         {ta, tw, tb, wr_resp} = {awvalid & awready, wvalid & wready, bvalid, bresp};
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask
   task automatic rd(fs_addr_t a);
      logic ta, tr;
      @(posedge clk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      tr = 1'b0;
      while (!tr) begin
         @(negedge clk);
         {ta, tr, rdv, rd_resp} = {arvalid & arready, rvalid, rdata, rresp};
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cause === 1'b1) causes <= causes + 1;
      if (sys_rst === 1'b1) begin
         if (pulses == 0) t_first <= cyc;
         pulses <= pulses + 1;
         {t_prev, t_last} <= {t_last, cyc};
      end
   end
   initial begin
      repeat (40000) @(posedge clk);
      err_count++;
      summarize();
   end
   initial begin
      {rst, awvalid, wvalid, bready, arvalid, rready, sel_req} = 7'h40;
      {awaddr, araddr, wdata, wstrb} = {12'h0, 32'h0, 4'hF};
      {ref_h, one_h, ext_h, seed} = {12'h222, 32'd89662};
      {err_count, samples_checked, pulses, causes, cyc} = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         rd(fs_addr_t'(4 * i));
         chk("reset value", rdv, rst_val[i]);
         chk("read resp", 32'(rd_resp), (i == 9) ? 32'h2 : 32'h0);
      end
      wr(FS_OFS_HI0, xs());
      rd(FS_OFS_HI0);
      chk("locked", rdv, 32'h0);
      foreach (rst_val[i]) begin
         v = (i % 3 == 0) ? 32'hF9 : xs();
         wr(FS_OFS_WCTL, v);
         rd(FS_OFS_WCTL);
         chk("write ctrl", rdv, (v[7:0] == 8'hF9) ? 32'hF9 : 32'h6);
      end
      for (int i = 0; i < 4; i++) begin
         v = xs();
         wr(fs_addr_t'(8 + 4 * i), v);
         chk("write resp", 32'(wr_resp), 32'h0);
         rd(fs_addr_t'(8 + 4 * i));
         chk("limit", rdv, v & 32'h1FF);
      end
      wr(6'h24, 32'h1);
      chk("unmapped", 32'(wr_resp), 32'h2);
      wr(FS_OFS_DCTL, 32'h55);
      rd(FS_OFS_DCTL);
      chk("bad code", rdv, 32'h0);
      $display("test registers done");
      wr(FS_OFS_RST, 32'h0);
      wr(FS_OFS_LO1, 32'h3B);
      wr(FS_OFS_HI1, 32'h46);
      wr(FS_OFS_DCTL, 32'hE4);
      rd(FS_OFS_STAT);
      chk("running", rdv, stat(0, 1));
      wr(FS_OFS_HI1, 32'h1FF);
      wr(FS_OFS_MON, 32'h0);
      rd(FS_OFS_HI1);
      chk("held limit", rdv, 32'h46);
      rd(FS_OFS_MON);
      chk("held monitor", rdv, 32'h1);
      repeat (4 * WIN) @(posedge clk);
      rd(FS_OFS_STAT);
      chk("good target", rdv, stat(0, 1));
      ext_h <= 4'h4;
      repeat (5 * WIN) @(posedge clk);
      rd(FS_OFS_STAT);
      chk("slow target", rdv, stat(1, 1));
      chk("no reset", 32'(pulses), 32'h0);
      wr(FS_OFS_DCTL, 32'h0);
      rd(FS_OFS_STAT);
      chk("stopped", rdv, stat(0, 0));
      $display("test monitor done");
      wr(FS_OFS_RST, 32'h1);
      wr(FS_OFS_MON, 32'h0);
      wr(FS_OFS_LO0, 32'h3B);
      wr(FS_OFS_HI0, 32'h46);
      one_h <= 4'h4;
      sel_req <= 1'b1;
      wr(FS_OFS_DCTL, 32'hE4);
      t0 = cyc;
      repeat (8 * WIN) @(posedge clk);
      chk("first delay", 32'(t_first - t0 >= 5 * WIN - 16 && t_first - t0 <= 5 * WIN + 16), 1);
      chk("spacing", 32'(t_last - t_prev), WIN);
      chk("causes", 32'(causes), 32'(pulses));
      rd(FS_OFS_STAT);
      chk("still running", rdv, stat(1, 1));
      one_h <= 4'h2;
      repeat (3 * WIN + 16) @(posedge clk);
      t0 = pulses;
      repeat (2 * WIN) @(posedge clk);
      chk("resets stop", 32'(pulses - t0), 32'h0);
      rd(FS_OFS_STAT);
      chk("recovered", rdv, stat(0, 1));
      wr(FS_OFS_WCTL, 32'h6);
      wr(FS_OFS_DCTL, 32'h0);
      rd(FS_OFS_DCTL);
      chk("relocked", rdv, 32'hE4);
      $display("test reset generation done");
      summarize();
   end
endmodule
